/* qsb_burst_port.sv */
/*
 * four-word burst sram with separate read and write ports, byte masking,
 * read-after-write coherency and a two-entry buffer on the read data path.
 * assumes clk edges alternate positive (even slot) and negative (odd slot)
 * input clock rises, counted from reset release; inputs synchronous to clk.
 */
// How it works
// - write taken on positive edge t; four words follow over t+1 and t+2
// - read taken on positive edge; words leave from t+2.5 through t+4
// - write data captured and read data launched on every clock edge
// - burst walks latched address A with beat 0, 1, 2, 3 appended as low bits internally
// - after reset the port is deselected and read outputs are not driven
// - same operation on the next positive edge is discarded
// - a select low when last cycle started is treated as don't care
// - 18-bit words: two active-low selects gate bits 8:0 and 17:9
// - 36-bit words: four selects gate 8:0, 17:9, 26:18, 35:27
// - all selects high writes nothing for that word
// - byte selects are sampled with each word separately
// - both selects low: read wins unless a read started last cycle or the read pipeline is stalled
// - read-valid rises half a cycle ahead of read data
// - read just after write of same location returns the newest data
`timescale 1ns/1ps
`default_nettype none
module qsb_burst_port #(
	parameter int ADDR_W = 18,
	parameter int DATA_W = 18
) (
	input  wire logic                      clk,
	input  wire logic                      rst,
	input  wire logic                      read_port_select_n,
	input  wire logic                      write_port_select_n,
	input  wire logic [ADDR_W-1:0]         addr,
	input  wire logic [DATA_W-1:0]         wr_data,
	input  wire logic [DATA_W/9-1:0]       byte_write_select_n,
	input  wire logic                      rd_ready,
	output logic      [DATA_W-1:0]         rd_data,
	output logic                           rd_valid,
	output logic                           rd_oe,
	output logic                           read_valid_out,
	output logic                           k_phase
);
	localparam int NB = DATA_W / qsb_pkg::BYTE_W;
	localparam int MW = ADDR_W + 2;

	// =====================================================================
	// storage and pipeline state
	// =====================================================================
	logic [DATA_W-1:0]                mem [0:(2**MW)-1];
	logic                             phase_reg;
	qsb_pkg::qsb_last_t               last_reg;
	logic [qsb_pkg::RD_SR_LEN-1:0]    rd_sr_reg;
	logic [qsb_pkg::WR_SR_LEN-1:0]    wr_sr_reg;
	logic [ADDR_W-1:0]                rd_base_reg;
	logic [ADDR_W-1:0]                rd_act_reg;
	logic [ADDR_W-1:0]                wr_base_reg;
	logic [ADDR_W-1:0]                wr_act_reg;
	logic [DATA_W-1:0]                buf_reg [0:qsb_pkg::BUF_DEPTH-1];
	logic [1:0]                       buf_cnt_reg;
	logic                             rvo_reg;
	qsb_pkg::qsb_start_t              start;
	logic                             rd_push;
	logic [1:0]                       rd_beat;
	logic                             wr_take;
	logic [1:0]                       wr_beat;
	logic                             buf_pop;
	logic                             buf_full;
	logic                             stall;
	logic [DATA_W-1:0]                rd_word;

	function automatic logic [MW-1:0] word_addr(input logic [ADDR_W-1:0] a,
		input logic [1:0] beat);
		word_addr = {a, beat};
	endfunction

	// =====================================================================
	// request decode and arbitration
	// =====================================================================
	always_comb
	begin
		logic rd_ok;
		logic wr_ok;
		rd_ok = 1'b0;
		wr_ok = 1'b0;
		start = '{rd: 1'b0, wr: 1'b0};
		if (phase_reg == 1'h0)
		begin
			// a select low right after its own start is ignored
			rd_ok = !read_port_select_n && (last_reg != qsb_pkg::QSB_LAST_READ) && !stall;
			wr_ok = !write_port_select_n && (last_reg != qsb_pkg::QSB_LAST_WRITE);
			if (rd_ok && wr_ok)
				start.rd = 1'b1;
			else
			begin
				start.rd = rd_ok;
				start.wr = wr_ok;
			end
		end
	end

	// =====================================================================
	// per-edge beat selection
	// =====================================================================
	always_comb
	begin
		rd_push = 1'b0;
		rd_beat = 2'h0;
		wr_take = 1'b0;
		wr_beat = 2'h0;
		for (int i = 0; i < qsb_pkg::BURST_LEN; i++)
		begin
			if (rd_sr_reg[qsb_pkg::RD_FIRST_OFS + i - 1])
			begin
				rd_push = 1'b1;
				rd_beat = i[1:0];
			end
			if (wr_sr_reg[qsb_pkg::WR_FIRST_OFS + i - 1])
			begin
				wr_take = 1'b1;
				wr_beat = i[1:0];
			end
		end
	end

	assign buf_full = (buf_cnt_reg == 2'(qsb_pkg::BUF_DEPTH));
	assign buf_pop  = rd_valid && rd_ready;
	// a word that cannot enter the buffer freezes the read pipeline
	assign stall    = rd_push && buf_full && !buf_pop;
	assign rd_word  = mem[word_addr(rd_act_reg, rd_beat)];

	// =====================================================================
	// half-cycle phase and last started operation
	// =====================================================================
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			phase_reg <= qsb_pkg::PHASE_RST;
			last_reg  <= qsb_pkg::QSB_LAST_NONE;
		end
		else
		begin
			phase_reg <= !phase_reg;
			if (phase_reg == 1'h0)
			begin
				if (start.rd)
					last_reg <= qsb_pkg::QSB_LAST_READ;
				else if (start.wr)
					last_reg <= qsb_pkg::QSB_LAST_WRITE;
				else
					last_reg <= qsb_pkg::QSB_LAST_NONE;
			end
		end
	end

	// =====================================================================
	// write pipeline and array update
	// =====================================================================
	always_ff @(posedge clk)
	begin
		if (rst)
			wr_sr_reg <= '0;
		else
			wr_sr_reg <= {wr_sr_reg[qsb_pkg::WR_SR_LEN-2:0], start.wr};
	end

	always_ff @(posedge clk)
	begin
		if (start.wr)
			wr_base_reg <= addr;
		if (wr_sr_reg[0])
			wr_act_reg <= wr_base_reg;
	end

	// data taken on every edge; each lane gated by its own select
	always_ff @(posedge clk)
	begin
		if (!rst && wr_take)
		begin
			for (int b = 0; b < NB; b++)
			begin
				if (!byte_write_select_n[b])
					mem[word_addr(wr_act_reg, wr_beat)][b*qsb_pkg::BYTE_W +: qsb_pkg::BYTE_W]
						<= wr_data[b*qsb_pkg::BYTE_W +: qsb_pkg::BYTE_W];
			end
		end
	end

	// =====================================================================
	// read pipeline
	// =====================================================================
	always_ff @(posedge clk)
	begin
		if (rst)
			rd_sr_reg <= '0;
		else if (!stall)
			rd_sr_reg <= {rd_sr_reg[qsb_pkg::RD_SR_LEN-2:0], start.rd};
	end

	always_ff @(posedge clk)
	begin
		if (start.rd)
			rd_base_reg <= addr;
		if (rd_sr_reg[qsb_pkg::RD_FIRST_OFS-2] && !stall)
			rd_act_reg <= rd_base_reg;
	end

	// flag leads the first word by one edge
	always_ff @(posedge clk)
	begin
		if (rst)
			rvo_reg <= 1'b0;
		else if (!stall)
			rvo_reg <= |rd_sr_reg[qsb_pkg::RD_VALID_OFS+qsb_pkg::BURST_LEN-3:qsb_pkg::RD_VALID_OFS-2];
	end

	// =====================================================================
	// two-entry read buffer, head drives the pins
	// =====================================================================
	always_ff @(posedge clk)
	begin
		if (rst)
			buf_cnt_reg <= 2'h0;
		else
			buf_cnt_reg <= buf_cnt_reg + 2'(rd_push && !stall) - 2'(buf_pop);
	end

	// array read sees writes of earlier edges, so a following read is coherent
	always_ff @(posedge clk)
	begin
		if (rd_push && !stall)
		begin
			if (buf_cnt_reg == 2'h0 || (buf_cnt_reg == 2'h1 && buf_pop))
				buf_reg[0] <= rd_word;
			else
				buf_reg[1] <= rd_word;
		end
		if (buf_pop && buf_cnt_reg == 2'h2)
			buf_reg[0] <= buf_reg[1];
	end

	// =====================================================================
	// outputs
	// =====================================================================
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			rd_data        <= '0;
			rd_valid       <= 1'b0;
			rd_oe          <= 1'b0;
			read_valid_out <= 1'b0;
			k_phase        <= 1'b0;
		end
		else
		begin
			read_valid_out <= rvo_reg;
			k_phase        <= !phase_reg;
			if (rd_push && !stall && (buf_cnt_reg == 2'h0 ||
				(buf_cnt_reg == 2'h1 && buf_pop)))
				rd_data <= rd_word;
			else if (buf_pop && buf_cnt_reg == 2'h2)
				rd_data <= buf_reg[1];
			rd_valid <= (buf_cnt_reg + 2'(rd_push && !stall) - 2'(buf_pop)) != 2'h0;
			rd_oe    <= (buf_cnt_reg + 2'(rd_push && !stall) - 2'(buf_pop)) != 2'h0;
		end
	end
endmodule
`default_nettype wire

/* qsb_pkg.sv */
/*
 * shared constants and carriers of the burst port: slot offsets of the
 * read and write pipelines, byte lane size, buffer depth.
 * assumes one clock whose edges alternate positive and negative input clock.
 */
package qsb_pkg;
	// =====================================================================
	// timing, counted in clock edges (one edge per half cycle)
	// =====================================================================
	localparam int BURST_LEN    = 4;
	localparam int WR_FIRST_OFS = 2;
	localparam int RD_FIRST_OFS = 5;
	localparam int RD_VALID_OFS = RD_FIRST_OFS - 1;
	localparam int RD_SR_LEN    = RD_FIRST_OFS + BURST_LEN - 1;
	localparam int WR_SR_LEN    = WR_FIRST_OFS + BURST_LEN - 1;
	localparam int BYTE_W       = 9;
	localparam int BUF_DEPTH    = 2;
	// =====================================================================
	// reset values
	// =====================================================================
	localparam logic PHASE_RST  = 1'h0;
	typedef enum logic [1:0] {
		QSB_LAST_NONE  = 2'h0,
		QSB_LAST_READ  = 2'h1,
		QSB_LAST_WRITE = 2'h2
	} qsb_last_t;
	typedef struct packed {
		logic rd;
		logic wr;
	} qsb_start_t;
endpackage

/* qsb_burst_port_assertions.sv */
/* checker on the burst port read side
   assumes it is bound into the design top and sees its ports only */
`timescale 1ns/1ps
`default_nettype none
module qsb_burst_port_assertions #(
	parameter int DATA_W = 18
) (
	input wire logic              clk,
	input wire logic              rst,
	input wire logic              read_port_select_n,
	input wire logic              rd_ready,
	input wire logic [DATA_W-1:0] rd_data,
	input wire logic              rd_valid,
	input wire logic              rd_oe,
	input wire logic              read_valid_out,
	input wire logic              k_phase
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	// accepted read on a positive edge with the buffer draining
	sequence s_rd;
		!k_phase && !read_port_select_n && $past(read_port_select_n, 2)
			&& $past(rd_ready) && rd_ready;
	endsequence
	property p_rst_idle;
		$past(rst) |-> !rd_oe && !rd_valid && !read_valid_out;
	endproperty
	a_rst_idle: assert property (p_rst_idle) else $error("output active after reset");
	property p_oe;
		rd_oe == rd_valid;
	endproperty
	a_oe: assert property (p_oe) else $error("drive enable without word");
	property p_phase;
		1'b1 |=> k_phase != $past(k_phase);
	endproperty
	a_phase: assert property (p_phase) else $error("edge phase stuck");
	property p_rd_lat;
		s_rd ##1 rd_ready [*8] |-> read_valid_out && $past(read_valid_out, 3);
	endproperty
	a_rd_lat: assert property (p_rd_lat) else $error("read burst timing wrong");
	property p_rvo_lead;
		$rose(read_valid_out) && rd_ready |=> rd_valid;
	endproperty
	a_rvo_lead: assert property (p_rvo_lead) else $error("valid flag not ahead of data");
	property p_rep;
		s_rd ##2 !read_port_select_n ##2 read_port_select_n ##1 rd_ready [*6] |-> !read_valid_out;
	endproperty
	a_rep: assert property (p_rep) else $error("repeated read not discarded");
	property p_hold;
		rd_valid && !rd_ready |=> rd_valid && $stable(rd_data);
	endproperty
	a_hold: assert property (p_hold) else $error("stalled word lost");
	property p_idle;
		(read_port_select_n && rd_ready) [*8] |=> !read_valid_out ##1 !rd_valid;
	endproperty
	a_idle: assert property (p_idle) else $error("output without read");
endmodule
bind qsb_burst_port qsb_burst_port_assertions #(.DATA_W(DATA_W)) chk (.clk, .rst,
	.read_port_select_n, .rd_ready, .rd_data, .rd_valid, .rd_oe, .read_valid_out, .k_phase);
`default_nettype wire

/* qsb_ctrl_model.sv */
/* memory controller model: issues bursts and takes read words
   assumes the clock runs free, so it never rests; a stop would rest high */
`timescale 1ns/1ps
`default_nettype none
module qsb_ctrl_model #(
	parameter int ADDR_W = 4,
	parameter int DATA_W = 36
) (
	input  wire logic                clk,
	input  wire logic                k_phase,
	input  wire logic [DATA_W-1:0]   rd_data,
	input  wire logic                rd_valid,
	output logic                     read_port_select_n,
	output logic                     write_port_select_n,
	output logic      [ADDR_W-1:0]   addr,
	output logic      [DATA_W-1:0]   wr_data,
	output logic      [DATA_W/9-1:0] byte_write_select_n,
	output logic                     rd_ready
);
	logic [DATA_W-1:0] got [$];
	initial
	begin
		read_port_select_n = 1'b1;
		write_port_select_n = 1'b1;
		addr = '0;
		wr_data = '0;
		byte_write_select_n = '1;
		rd_ready = 1'b1;
	end
	int edge_n = 0;
	int sel_at = 0;
	int first_at = 0;
	// edge count, and the edge at which the first word of a burst is taken
	always @(posedge clk)
	begin
		edge_n <= edge_n + 1;
		if (rd_valid && rd_ready)
		begin
			if (got.size() == 0)
				first_at <= edge_n + 1;
			got.push_back(rd_data);
		end
	end
	// fwd: a write followed by a read of the same address on the next even slot
	task automatic op(input bit rd, input bit dup, input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] d [4], input logic [DATA_W/9-1:0] m [4],
		input bit fwd);
		@(posedge clk);
		#1;
		while (k_phase)
		begin
			@(posedge clk);
			#1;
		end
		addr = a;
		sel_at = edge_n + 1;
		read_port_select_n = !rd;
		write_port_select_n = rd;
		for (int e = 0; e < 6; e++)
		begin
			@(posedge clk);
			#1;
			read_port_select_n = !(((rd && dup) || fwd) && e == 1);
			write_port_select_n = !(!rd && dup && e == 1);
			addr = (fwd && e == 1) ? a : ~a;
			wr_data = (!rd && e > 0 && e < 5) ? d[e-1] : ~wr_data;
			byte_write_select_n = (!rd && e > 0 && e < 5) ? m[e-1] : '1;
		end
	endtask
endmodule
`default_nettype wire

/* qsb_burst_port_bench.sv */
/* bench for the burst port: random masked bursts, repeats, stall
   assumes the controller model drives every design input but clk and rst */
`timescale 1ns/1ps
`default_nettype none
module qsb_burst_port_bench;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [35:0] mem [64];
	logic [35:0] d [4];
	logic [3:0]  m [4];
	logic [3:0]  a;
	integer      seed = 32'h2420;
	int          n_fail = 0;
	int          num_checks = 0;
	wire logic   read_port_select_n, write_port_select_n, rd_ready, rd_valid;
	wire logic   rd_oe, read_valid_out, k_phase;
	wire logic [3:0]  addr, byte_write_select_n;
	wire logic [35:0] wr_data, rd_data;
	wire logic [17:0] rd_data18;
	wire logic        rd_valid18;
	logic [17:0]      got18 [$];
	qsb_burst_port #(.ADDR_W(4), .DATA_W(36)) uut (.clk, .rst, .read_port_select_n,
		.write_port_select_n, .addr, .wr_data, .byte_write_select_n, .rd_ready,
		.rd_data, .rd_valid, .rd_oe, .read_valid_out, .k_phase);
	qsb_ctrl_model #(.ADDR_W(4), .DATA_W(36)) pm (.clk, .k_phase, .rd_data, .rd_valid,
		.read_port_select_n, .write_port_select_n, .addr, .wr_data,
		.byte_write_select_n, .rd_ready);
	// 18-bit organization runs in lockstep on the low two lanes
	qsb_burst_port #(.ADDR_W(4), .DATA_W(18)) uut18 (.clk, .rst, .read_port_select_n,
		.write_port_select_n, .addr, .wr_data(wr_data[17:0]),
		.byte_write_select_n(byte_write_select_n[1:0]), .rd_ready, .rd_data(rd_data18),
		.rd_valid(rd_valid18), .rd_oe(), .read_valid_out(), .k_phase());
	always @(posedge clk)
		if (rd_valid18 && rd_ready)
			got18.push_back(rd_data18);
	function automatic logic [35:0] merge(logic [35:0] o, logic [35:0] n, logic [3:0] k);
		for (int b = 0; b < 4; b++)
			if (!k[b])
				o[9*b +: 9] = n[9*b +: 9];
		return o;
	endfunction
	task automatic chk(input logic [35:0] g, input logic [35:0] e);
		num_checks++;
		if (g !== e)
		begin
			n_fail++;
			$display("wrong value at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task automatic stop_test();
		if (n_fail == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic take(input logic [3:0] ra, input int lat);
		for (int w = 0; w < 30 && pm.got.size() < 4; w++)
			@(posedge clk);
		repeat (8) @(posedge clk);
		if (lat > 0)
			chk(36'(pm.first_at - pm.sel_at), 36'(lat));
		chk(36'(pm.got.size()), 36'h4);
		chk(36'(got18.size()), 36'h4);
		for (int k = 0; k < 4 && k < pm.got.size(); k++)
			chk(pm.got[k], mem[{ra, 2'(k)}]);
		for (int k = 0; k < 4 && k < got18.size(); k++)
			chk(36'(got18[k]), 36'(mem[{ra, 2'(k)}][17:0]));
	endtask
	task automatic wr(input logic [3:0] wa, input bit dup, input bit full, input bit fwd);
		for (int k = 0; k < 4; k++)
		begin
			d[k] = {4'($random(seed)), 32'($random(seed))};
			m[k] = full ? 4'h0 : 4'($random(seed));
			mem[{wa, 2'(k)}] = merge(mem[{wa, 2'(k)}], d[k], m[k]);
		end
		pm.got.delete();
		got18.delete();
		pm.op(1'b0, dup, wa, d, m, fwd);
		if (fwd)
			take(wa, qsb_pkg::RD_FIRST_OFS + 3);
	endtask
	task automatic rd(input logic [3:0] ra, input bit dup, input bit stall);
		pm.got.delete();
		got18.delete();
		pm.rd_ready = !stall;
		pm.op(1'b1, dup, ra, d, m, 1'b0);
		if (stall)
		begin
			repeat (8) @(posedge clk);
			#1;
			chk(36'(pm.got.size()), 36'h0);
			chk(36'(rd_valid), 36'h1);
			pm.rd_ready = 1'b1;
		end
		take(ra, stall ? 0 : qsb_pkg::RD_FIRST_OFS + 1);
	endtask
	initial
	begin
		forever #20 clk = ~clk;
	end
	initial
	begin
		#(40 * 5000);
		n_fail++;
		stop_test();
	end
	initial
	begin
		repeat (4) @(posedge clk);
		#1;
		rst = 1'b0;
		for (int k = 0; k < 16; k++)
			wr(4'(k), 1'b0, 1'b1, 1'b0);
		for (int k = 0; k < 14; k++)
		begin
			a = 4'($random(seed));
			wr(a, k == 3, k == 0, k == 9);
			rd(k == 3 ? ~a : a, k == 5, k == 7);
		end
		stop_test();
	end
endmodule
`default_nettype wire
